// *** design/sensor_out_pkg.sv ***
// Shared constants, register map and helpers for the incremental output block.
// Assumes a 100 MHz system clock and 14-bit compensated angle samples.
package sensor_out_pkg;

	localparam int ANGLE_W = 14;
	localparam int FILT_W  = 12;
	localparam int ADDR_W  = 8;
	localparam int WIN_W   = 6;
	localparam int SLEW_W  = 8;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFF   = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h04;
	localparam logic [ADDR_W-1:0] FILT_OFF   = 8'h08;
	localparam logic [ADDR_W-1:0] ANGLE_OFF  = 8'h0C;

	// Control register fields
	localparam int ROUTE_BIT = 0;
	localparam int IDX_LSB   = 1;
	localparam int POLE_LSB  = 4;
	localparam int WIN_LSB   = 8;
	localparam int SLEW_LSB  = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK  = 32'h00FF_3FF7;

	// Status register fields
	localparam int DIR_BIT     = 0;
	localparam int PHASE_LSB   = 1;
	localparam int DEFINED_BIT = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SLEW_UNIT_NS   = 1000;
	localparam int SLEW_UNIT_CYC  = (SLEW_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PO_TIME_US     = 100;
	localparam int PO_CYCLES      = PO_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int DELAY_TIME_US  = 100;
	localparam int DELAY_CYCLES   = DELAY_TIME_US * 1000 / CLK_PERIOD_NS;

	// Index pulse widths in quadrature states, one per code
	localparam int IDX_STATES [4] = '{1, 2, 3, 4};

	typedef enum logic [1:0] {PH_POWER_ON, PH_DELAY, PH_CATCHUP, PH_RUN} phase_t;

	// Three-phase pattern for each 90 electrical degree sector
	function automatic logic [2:0] comm_pattern(input logic [1:0] sector);
		unique case (sector)
			2'h0: comm_pattern = 3'h4;
			2'h1: comm_pattern = 3'h6;
			2'h2: comm_pattern = 3'h3;
			2'h3: comm_pattern = 3'h1;
		endcase
	endfunction : comm_pattern

endpackage : sensor_out_pkg

// *** design/angle_window_hysteresis.sv ***
// Angle hysteresis window: output follows the head, holds inside the window.
// Assumes one angle sample per valid pulse, same clock as the caller.
module angle_window_hysteresis #(
	parameter int ANGLE_W = 14,
	parameter int WIN_W   = 6
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               restart,
	input  wire logic               sample_valid,
	input  wire logic [ANGLE_W-1:0] sample_angle,
	input  wire logic [WIN_W-1:0]   window,
	output logic      [ANGLE_W-1:0] filt_angle,
	output logic                    direction
);

	typedef struct packed {
		logic               primed;
		logic               dir;
		logic [ANGLE_W-1:0] ang;
	} hys_t;

	hys_t s_q;
	hys_t s_d;

	always_comb
	begin
		logic [ANGLE_W-1:0] delta;
		logic [ANGLE_W-1:0] fwd;
		logic [ANGLE_W-1:0] back;
		delta = ANGLE_W'(sample_angle - s_q.ang);
		fwd   = s_q.dir ? ANGLE_W'(-delta) : delta;
		back  = ANGLE_W'(-fwd);
		s_d   = s_q;
		if (restart)
		begin
			s_d.primed = 1'b0;
			s_d.dir    = 1'b0;
		end
		else if (sample_valid)
		begin
			if (!s_q.primed)
			begin
				// Window starts behind the first angle
				s_d.primed = 1'b1;
				s_d.dir    = 1'b0;
				s_d.ang    = sample_angle;
			end
			else if (!fwd[ANGLE_W-1])
				s_d.ang = sample_angle;
			else if (back > ANGLE_W'(window))
			begin
				s_d.dir = ~s_q.dir;
				s_d.ang = sample_angle;
			end
			// Otherwise held inside the window
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign filt_angle = s_q.ang;
	assign direction  = s_q.dir;

endmodule : angle_window_hysteresis

// *** design/incremental_commutation_output.sv ***
// Quadrature, index and commutation outputs driven from the angle samples,
// with power-up catch-up and optional angle hysteresis, AXI4-Lite registers.
// Assumes angle samples and self-test pulse come from logic on aclk.
//
// How it works
// - Index pulse marks zero, four selectable widths
// - Four-bit pole code n gives n+1 pairs
// - Commutation changes every 90 electrical degrees
// - Routing bit selects hysteresis angle for outputs
// - Outputs undefined during power-on interval
// - Delay phase shows zero angle: A,B low, I high
// - Catch-up steps shorter way, one state per interval
// - Slew setting zero: jump straight to angle
// - Window width counts 360/16384 degree units
// - Filtered angle readable at 12-bit resolution
// - Same direction: output tracks sensor angle
// - Reversal: output holds until window exit
// - Exit on far side flips direction
// - Direction status bit, 0 increasing, 1 decreasing
// - Reset and self-test restart direction increasing
// - Quadrature Gray order 00,01,11,10 increasing
// - Nonzero slew setting steps through valid states
module incremental_commutation_output #(
	parameter int QUAD_BITS    = 12,
	parameter int PO_CYCLES    = sensor_out_pkg::PO_CYCLES,
	parameter int DELAY_CYCLES = sensor_out_pkg::DELAY_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Angle source
	input  wire logic        angle_valid,
	input  wire logic [13:0] angle_in,
	input  wire logic        logic_self_test_done,
	// Encoder and motor outputs
	output logic             quad_a,
	output logic             quad_b,
	output logic             index_out,
	output logic [2:0]       commutation_outputs,
	output logic             outputs_defined,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	localparam int AW     = sensor_out_pkg::ANGLE_W;
	localparam int SW     = sensor_out_pkg::SLEW_W;
	localparam int PRE    = sensor_out_pkg::SLEW_UNIT_CYC;
	localparam int IDX_W  = 2;
	localparam int POLE_W = 4;

	typedef struct packed {
		logic [31:0]                       ctrl;
		sensor_out_pkg::phase_t            phase;
		logic [31:0]                       timer;
		logic [7:0]                        pre;
		logic [SW-1:0]                     slew_cnt;
		logic [QUAD_BITS-1:0]              pos;
		logic                              a;
		logic                              b;
		logic                              idx;
		logic [2:0]                        comm;
		logic                              aw_have;
		logic [sensor_out_pkg::ADDR_W-1:0] awaddr;
		logic                              w_have;
		logic [31:0]                       wdata;
		logic [3:0]                        wstrb;
		logic                              bvalid;
		logic [1:0]                        bresp;
		logic                              rvalid;
		logic [31:0]                       rdata;
		logic [1:0]                        rresp;
	} state_t;

	state_t s_q;
	state_t s_d;

	// One quadrature state toward the target, the shorter way round
	function automatic logic [QUAD_BITS-1:0] step_toward(
		input logic [QUAD_BITS-1:0] pos,
		input logic [QUAD_BITS-1:0] diff
	);
		if (diff[QUAD_BITS-1])
			step_toward = QUAD_BITS'(pos - 1'b1);
		else
			step_toward = QUAD_BITS'(pos + 1'b1);
	endfunction : step_toward

	// Low two position bits to the A and B lines in Gray order
	function automatic logic [1:0] quad_lines(input logic [QUAD_BITS-1:0] pos);
		quad_lines = {pos[1], pos[1] ^ pos[0]};
	endfunction : quad_lines

	// Lanes not strobed keep their value; unused bits always read zero
	function automatic logic [31:0] merge_lanes(
		input logic [31:0] cur,
		input logic [31:0] wdat,
		input logic [3:0]  strb
	);
		merge_lanes = cur;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				merge_lanes[8*i +: 8] = wdat[8*i +: 8] & sensor_out_pkg::CTRL_MASK[8*i +: 8];
	endfunction : merge_lanes

	// Offsets that answer OKAY; anything else is refused with SLVERR
	function automatic logic reg_known(input logic [sensor_out_pkg::ADDR_W-1:0] addr);
		reg_known = addr == sensor_out_pkg::CTRL_OFF
			|| addr == sensor_out_pkg::STATUS_OFF
			|| addr == sensor_out_pkg::FILT_OFF
			|| addr == sensor_out_pkg::ANGLE_OFF;
	endfunction : reg_known

	logic [AW-1:0]     filt_angle;
	logic              filt_dir;
	logic              route_filt;
	logic [IDX_W-1:0]  idx_code;
	logic [POLE_W-1:0] pole_code;
	logic [5:0]        win_width;
	logic [SW-1:0]     slew_time;

	assign route_filt = s_q.ctrl[sensor_out_pkg::ROUTE_BIT];
	assign idx_code   = s_q.ctrl[sensor_out_pkg::IDX_LSB +: IDX_W];
	assign pole_code  = s_q.ctrl[sensor_out_pkg::POLE_LSB +: POLE_W];
	assign win_width  = s_q.ctrl[sensor_out_pkg::WIN_LSB +: sensor_out_pkg::WIN_W];
	assign slew_time  = s_q.ctrl[sensor_out_pkg::SLEW_LSB +: SW];

	// Window field is in 14-bit angle LSBs, so it compares with raw samples directly
	angle_window_hysteresis #(
		.ANGLE_W (AW),
		.WIN_W   (sensor_out_pkg::WIN_W)
	) u_hys (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.restart      (logic_self_test_done),
		.sample_valid (angle_valid),
		.sample_angle (angle_in),
		.window       (win_width),
		.filt_angle   (filt_angle),
		.direction    (filt_dir)
	);

	always_comb
	begin
		logic [AW-1:0]        sel_angle;
		logic [QUAD_BITS-1:0] target;
		logic [QUAD_BITS-1:0] diff;
		logic [AW+4:0]        elec;
		logic                 tick;
		logic                 step;
		logic                 wr_go;
		logic [31:0]          status;
		// Every local starts defined so no path leaves a latch behind
		sel_angle = '0;
		target    = '0;
		diff      = '0;
		elec      = '0;
		tick      = 1'b0;
		step      = 1'b0;
		wr_go     = 1'b0;
		status    = '0;
		s_d = s_q;

		sel_angle = route_filt ? filt_angle : angle_in;
		target    = sel_angle[AW-1 -: QUAD_BITS];
		diff      = QUAD_BITS'(target - s_q.pos);

		// Slew interval: 1 us tick then count of ticks
		tick = (s_q.pre == 8'(PRE - 1));
		s_d.pre = tick ? 8'h00 : 8'(s_q.pre + 8'h01);
		step = 1'b0;
		if (tick)
		begin
			if (SW'(s_q.slew_cnt + 1'b1) >= slew_time)
			begin
				s_d.slew_cnt = '0;
				step = 1'b1;
			end
			else
				s_d.slew_cnt = SW'(s_q.slew_cnt + 1'b1);
		end

		unique case (s_q.phase)
			sensor_out_pkg::PH_POWER_ON:
			begin
				s_d.timer = s_q.timer + 32'h1;
				if (s_q.timer >= 32'(PO_CYCLES - 1))
				begin
					s_d.phase = sensor_out_pkg::PH_DELAY;
					s_d.timer = '0;
					s_d.pos   = '0;
				end
			end
			sensor_out_pkg::PH_DELAY:
			begin
				s_d.pos   = '0;
				s_d.timer = s_q.timer + 32'h1;
				if (s_q.timer >= 32'(DELAY_CYCLES - 1))
				begin
					s_d.phase    = sensor_out_pkg::PH_CATCHUP;
					s_d.slew_cnt = '0;
				end
			end
			sensor_out_pkg::PH_CATCHUP:
			begin
				if (slew_time == '0)
				begin
					s_d.pos   = target;
					s_d.phase = sensor_out_pkg::PH_RUN;
				end
				else if (diff == '0)
					s_d.phase = sensor_out_pkg::PH_RUN;
				// Shorter way round, one state per slew interval
				else if (step)
					s_d.pos = step_toward(s_q.pos, diff);
			end
			sensor_out_pkg::PH_RUN:
			begin
				if (slew_time == '0)
					s_d.pos = target;
				// Skipped states are walked through in order
				else if (step && diff != '0)
					s_d.pos = step_toward(s_q.pos, diff);
			end
		endcase

		// Pins are parked low while undefined so nothing floats to X
		if (s_d.phase == sensor_out_pkg::PH_POWER_ON)
		begin
			s_d.a    = 1'b0;
			s_d.b    = 1'b0;
			s_d.idx  = 1'b0;
			s_d.comm = '0;
		end
		else
		begin
			{s_d.a, s_d.b} = quad_lines(s_d.pos);
			s_d.idx = (32'(s_d.pos) < 32'(sensor_out_pkg::IDX_STATES[idx_code]));
			// Pole pairs scale mechanical to electrical angle
			elec = (AW+5)'(sel_angle) * (AW+5)'({1'b0, pole_code} + 5'h01);
			s_d.comm = sensor_out_pkg::comm_pattern(elec[AW-1 -: 2]);
		end

		// AXI4-Lite write channel
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_d.aw_have = 1'b1;
			s_d.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_d.w_have = 1'b1;
			s_d.wdata  = s_axi_wdata;
			s_d.wstrb  = s_axi_wstrb;
		end
		wr_go = s_q.aw_have && s_q.w_have;
		if (wr_go)
		begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			if (s_q.awaddr == sensor_out_pkg::CTRL_OFF)
			begin
				s_d.ctrl  = merge_lanes(s_q.ctrl, s_q.wdata, s_q.wstrb);
				s_d.bresp = sensor_out_pkg::RESP_OKAY;
			end
			// Read-only offsets accept and ignore writes
			else if (reg_known(s_q.awaddr))
				s_d.bresp = sensor_out_pkg::RESP_OKAY;
			else
				s_d.bresp = sensor_out_pkg::RESP_SLVERR;
		end
		else if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;

		// AXI4-Lite read channel
		status = '0;
		status[sensor_out_pkg::DIR_BIT]       = filt_dir;
		status[sensor_out_pkg::PHASE_LSB +: 2] = s_q.phase;
		status[sensor_out_pkg::DEFINED_BIT]   = (s_q.phase != sensor_out_pkg::PH_POWER_ON);
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = sensor_out_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				sensor_out_pkg::CTRL_OFF:   s_d.rdata = s_q.ctrl;
				sensor_out_pkg::STATUS_OFF: s_d.rdata = status;
				sensor_out_pkg::FILT_OFF:   s_d.rdata = 32'(filt_angle[AW-1 -: sensor_out_pkg::FILT_W]);
				sensor_out_pkg::ANGLE_OFF:  s_d.rdata = 32'(angle_in);
				default:
				begin
					s_d.rdata = '0;
					s_d.rresp = sensor_out_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q       <= '0;
			s_q.ctrl  <= sensor_out_pkg::CTRL_RESET;
			s_q.phase <= sensor_out_pkg::PH_POWER_ON;
		end
		else
			s_q <= s_d;
	end

	assign quad_a              = s_q.a;
	assign quad_b              = s_q.b;
	assign index_out           = s_q.idx;
	assign commutation_outputs = s_q.comm;
	assign outputs_defined     = (s_q.phase != sensor_out_pkg::PH_POWER_ON);

	assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
	assign s_axi_wready  = !s_q.w_have && !s_q.bvalid;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;

endmodule : incremental_commutation_output

// *** tb/quad_receiver.sv ***
// Receiver model for the quadrature lines: counts Gray steps, flags skips.
// Assumes the lines are sampled on the sending block's clock.
module quad_receiver (
	input  wire logic        aclk,
	input  wire logic        enable,
	input  wire logic        a,
	input  wire logic        b,
	output logic      [15:0] pos,
	output logic      [7:0]  skips
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] prev;
	logic [1:0] cur;
	assign cur = {a, a ^ b};
	always_ff @(posedge aclk)
	begin
		prev <= enable ? cur : 2'h0;
		// Lines carry no meaning until the sender says so
		if (!enable)
		begin
			pos   <= 16'h0000;
			skips <= 8'h00;
		end
		else if (cur - prev == 2'h1) pos <= pos + 16'h0001;
		else if (cur - prev == 2'h3) pos <= pos - 16'h0001;
		else if (cur - prev == 2'h2) skips <= skips + 8'h01;
	end
endmodule : quad_receiver

// *** tb/ico_checker.sv ***
// Port assertions for the incremental output block.
// Assumes one clock domain; bound to the design's top module below.
module ico_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        quad_a,
	input wire logic        quad_b,
	input wire logic        index_out,
	input wire logic [2:0]  commutation_outputs,
	input wire logic        outputs_defined,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_quiet_power_on : assert property (
		!outputs_defined |-> !quad_a && !quad_b && !index_out && commutation_outputs == 3'h0)
		else $error("outputs active in power-on");
	a_delay_zero_angle : assert property (
		$rose(outputs_defined) |=> (!quad_a && !quad_b && index_out) [*8])
		else $error("delay phase not at zero");
	a_write_answer : assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_write_refused : assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_read_answer : assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_read_held : assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_refused : assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	a_unmapped_error : assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	c_defined : cover property ($rose(outputs_defined));
	c_write : cover property (s_axi_bvalid && s_axi_bready);
	c_slverr : cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : ico_checker

bind incremental_commutation_output ico_checker u_chk (.*);

// *** tb/tb_incremental_commutation_output.sv ***
// Self-checking bench: AXI4-Lite tasks and one task per scenario.
// Assumes the design package, receiver model and checker compile first.
module tb_incremental_commutation_output;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        angle_valid = 1'b0;
	logic        logic_self_test_done = 1'b0;
	logic [13:0] angle_in = 14'h3FF0;
	logic        quad_a, quad_b, index_out, outputs_defined;
	logic [2:0]  commutation_outputs;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] rx_pos;
	logic [7:0]  rx_skips;
	int          error_cnt = 0, n_tests = 0, cyc = 0;

	always #5 aclk = ~aclk;

	// Short power-up counts keep the run brief
	incremental_commutation_output #(.PO_CYCLES(20), .DELAY_CYCLES(20)) DUT (.*);
	quad_receiver RX (.aclk(aclk), .enable(outputs_defined), .a(quad_a), .b(quad_b),
		.pos(rx_pos), .skips(rx_skips));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask : settle

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic       ta, tw, tb;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		repeat (50)
		begin
			// Sample mid-cycle so the edge's own updates cannot race us
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) break;
		end
		s_axi_bready <= 1'b0;
		chk({30'h0, r}, {30'h0, sensor_out_pkg::RESP_OKAY});
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		logic        ta, tv;
		logic [31:0] d;
		logic [1:0]  r;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		repeat (50)
		begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tv) break;
		end
		s_axi_rready <= 1'b0;
		chk(d & m, e);
		chk({30'h0, r}, {30'h0, er});
	endtask : rchk

	task automatic smp(input logic [13:0] v);
		@(posedge aclk);
		angle_in <= v;
		angle_valid <= 1'b1;
		@(posedge aclk);
		angle_valid <= 1'b0;
	endtask : smp

	task automatic t_power_up();
		rchk(sensor_out_pkg::CTRL_OFF, 32'hFFFF_FFFF, 32'h0, 2'h0);
		rchk(8'h10, 32'hFFFF_FFFF, 32'h0, 2'h2);
		wr(sensor_out_pkg::CTRL_OFF, 32'h0001_0000);
		settle(0);
		chk({31'h0, outputs_defined}, 32'h0);
		repeat (100) if (!outputs_defined) @(posedge aclk);
		settle(3);
		chk({29'h0, quad_a, quad_b, index_out}, 32'h1);
		settle(700);
		// Down by four proves the shorter way was taken
		chk({16'h0, rx_pos}, 32'h0000_FFFC);
		chk({24'h0, rx_skips}, 32'h0);
		rchk(sensor_out_pkg::STATUS_OFF, 32'hE, 32'hE, 2'h0);
	endtask : t_power_up

	task automatic t_hysteresis();
		wr(sensor_out_pkg::CTRL_OFF, 32'h0001_0800);
		smp(14'h3FC0);
		smp(14'h3FE8);
		rchk(sensor_out_pkg::FILT_OFF, 32'hFFF, 32'hFFA, 2'h0);
		rchk(sensor_out_pkg::STATUS_OFF, 32'h1, 32'h0, 2'h0);
		smp(14'h3FE0);
		rchk(sensor_out_pkg::FILT_OFF, 32'hFFF, 32'hFFA, 2'h0);
		wr(sensor_out_pkg::CTRL_OFF, 32'h0001_0801);
		settle(1500);
		chk({30'h0, quad_a, quad_b}, 32'h3);
		chk({16'h0, rx_pos}, 32'h0000_FFFA);
		smp(14'h3FDC);
		rchk(sensor_out_pkg::FILT_OFF, 32'hFFF, 32'hFF7, 2'h0);
		rchk(sensor_out_pkg::STATUS_OFF, 32'h1, 32'h1, 2'h0);
		@(posedge aclk);
		logic_self_test_done <= 1'b1;
		@(posedge aclk);
		logic_self_test_done <= 1'b0;
		smp(14'h3FD8);
		smp(14'h3FD4);
		rchk(sensor_out_pkg::STATUS_OFF, 32'h1, 32'h0, 2'h0);
		rchk(sensor_out_pkg::FILT_OFF, 32'hFFF, 32'hFF6, 2'h0);
		chk({24'h0, rx_skips}, 32'h0);
	endtask : t_hysteresis

	task automatic t_jump_index();
		@(posedge aclk);
		angle_in <= 14'h0004;
		for (int c = 0; c < 4; c++)
		begin
			wr(sensor_out_pkg::CTRL_OFF, 32'(c) << 1);
			settle(3);
			chk({29'h0, quad_a, quad_b, index_out}, {29'h0, 2'b01, c >= 1});
		end
	endtask : t_jump_index

	task automatic t_commutation();
		logic [2:0] pat [4];
		int         s;
		pat = '{3'h4, 3'h6, 3'h3, 3'h1};
		@(posedge aclk);
		angle_in <= 14'h0A10;
		for (int c = 0; c < 16; c++)
		begin
			wr(sensor_out_pkg::CTRL_OFF, 32'(c) << 4);
			settle(3);
			s = ((2576 * (c + 1)) % 16384) / 4096;
			chk({29'h0, commutation_outputs}, {29'h0, pat[s]});
		end
	endtask : t_commutation

	task automatic t_restart();
		// Reset clears the slew setting, so catch-up is skipped
		@(posedge aclk);
		aresetn <= 1'b0;
		angle_in <= 14'h0008;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		settle(1);
		chk({31'h0, outputs_defined}, 32'h0);
		settle(60);
		chk({29'h0, quad_a, quad_b, index_out}, 32'h6);
		rchk(sensor_out_pkg::STATUS_OFF, 32'hE, 32'hE, 2'h0);
	endtask : t_restart

	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_power_up();
		t_hysteresis();
		t_jump_index();
		t_commutation();
		t_restart();
		end_of_test();
	end

	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
endmodule : tb_incremental_commutation_output
